// [hdl/dcbp_regs.vh]
// Constants for the DC bus protection, brake and status lamp block.
// Assumes 12-bit unsigned bus samples from an external converter.
`ifndef DCBP_REGS_VH
`define DCBP_REGS_VH
`define DCBP_FULL_SCALE 12'hfff
`define DCBP_OV_TRIP 12'hd20
`define DCBP_UV_TRIP 12'h3d0
`define DCBP_UV_CLEAR 12'h480
`define DCBP_BRAKE_ON 12'hc30
`define DCBP_BRAKE_OFF 12'hb80
`endif

// [hdl/dcbp_top.v]
// DC bus over/under voltage detection, dynamic brake and status lamp.
// Assumes sample words and their strobe come from logic on clock_in,
// and config and fault-latch status from neighbouring sequencing logic.
// Lamp outputs lag their status inputs by one clock.
`include "dcbp_regs.vh"

// One fixed-level compare of a bus sample, at-or-above or at-or-below.
module dcbp_cmp #(
	parameter SAMPLE_W = 12,
	parameter AT_OR_ABOVE = 1,
	parameter [SAMPLE_W-1:0] LEVEL = {SAMPLE_W{1'b1}}
) (
	input wire [SAMPLE_W-1:0] sample_in,
	output reg hit_out
);
	// Levels are inclusive at both ends
	always @* begin
		if (AT_OR_ABOVE != 0) begin
			hit_out = (sample_in >= LEVEL);
		end else begin
			hit_out = (sample_in <= LEVEL);
		end
	end
endmodule

// Comparators, brake and lamp drive for one DC bus feedback word.
module dcbp_top #(
	parameter SAMPLE_W = 12
) (
	input wire clock_in,
	input wire reset_in,
	input wire [SAMPLE_W-1:0] bus_sample_in,
	input wire sample_valid_in,
	input wire config_ok_in,
	input wire hw_fail_in,
	input wire fault_latched_in,
	output reg bus_over_volt_flag_out,
	output reg bus_under_volt_flag_out,
	output reg brake_on_out,
	output reg fault_indicator_out,
	output reg healthy_indicator_out
);
	// Lamp modes: dark, healthy, fault
	localparam [1:0] LAMP_DARK = 2'h0;
	localparam [1:0] LAMP_GREEN = 2'h1;
	localparam [1:0] LAMP_RED = 2'h2;

	wire ov_hit;
	wire uv_set_hit;
	wire uv_clear_hit;
	wire brake_on_hit;
	wire brake_off_hit;

	reg nxt_ov;
	reg nxt_uv;
	reg nxt_brake;
	reg lamp_ok;
	reg [1:0] nxt_lamp_mode;
	reg nxt_red;
	reg nxt_green;

	// Full 12-bit span used as is, no scaling inside
	// Overvoltage trip, no release band
	dcbp_cmp #(
		.SAMPLE_W(SAMPLE_W),
		.AT_OR_ABOVE(1),
		.LEVEL(`DCBP_OV_TRIP)
	) u_ov_cmp (
		.sample_in(bus_sample_in),
		.hit_out(ov_hit)
	);

	// Undervoltage trip
	dcbp_cmp #(
		.SAMPLE_W(SAMPLE_W),
		.AT_OR_ABOVE(0),
		.LEVEL(`DCBP_UV_TRIP)
	) u_uv_set_cmp (
		.sample_in(bus_sample_in),
		.hit_out(uv_set_hit)
	);

	// Undervoltage release, above the trip to stop chatter
	dcbp_cmp #(
		.SAMPLE_W(SAMPLE_W),
		.AT_OR_ABOVE(1),
		.LEVEL(`DCBP_UV_CLEAR)
	) u_uv_clear_cmp (
		.sample_in(bus_sample_in),
		.hit_out(uv_clear_hit)
	);

	// Brake turn-on level
	dcbp_cmp #(
		.SAMPLE_W(SAMPLE_W),
		.AT_OR_ABOVE(1),
		.LEVEL(`DCBP_BRAKE_ON)
	) u_brake_on_cmp (
		.sample_in(bus_sample_in),
		.hit_out(brake_on_hit)
	);

	// Brake turn-off level
	dcbp_cmp #(
		.SAMPLE_W(SAMPLE_W),
		.AT_OR_ABOVE(0),
		.LEVEL(`DCBP_BRAKE_OFF)
	) u_brake_off_cmp (
		.sample_in(bus_sample_in),
		.hit_out(brake_off_hit)
	);

	// Only a strobed sample may move a flag or the brake
	always @* begin
		nxt_ov = bus_over_volt_flag_out;
		if (sample_valid_in) begin
			nxt_ov = ov_hit;
		end
	end

	// Set wins, so a bad pair of levels still gives a defined flag
	always @* begin
		nxt_uv = bus_under_volt_flag_out;
		if (sample_valid_in) begin
			if (uv_set_hit) begin
				nxt_uv = 1'b1;
			end else if (uv_clear_hit) begin
				nxt_uv = 1'b0;
			end
		end
	end

	// Between the two levels the brake keeps its last state
	always @* begin
		nxt_brake = brake_on_out;
		if (sample_valid_in) begin
			if (brake_on_hit) begin
				nxt_brake = 1'b1;
			end else if (brake_off_hit) begin
				nxt_brake = 1'b0;
			end
		end
	end

	// Dark wins over fault: a failed part cannot vouch for its own fault
	always @* begin
		lamp_ok = config_ok_in & ~hw_fail_in;
		if (!lamp_ok) begin
			nxt_lamp_mode = LAMP_DARK;
		end else if (fault_latched_in) begin
			nxt_lamp_mode = LAMP_RED;
		end else begin
			nxt_lamp_mode = LAMP_GREEN;
		end
	end

	always @* begin
		case (nxt_lamp_mode)
			LAMP_GREEN: begin
				nxt_red = 1'b0;
				nxt_green = 1'b1;
			end
			LAMP_RED: begin
				nxt_red = 1'b1;
				nxt_green = 1'b0;
			end
			LAMP_DARK: begin
				nxt_red = 1'b0;
				nxt_green = 1'b0;
			end
			default: begin
				nxt_red = 1'b0;
				nxt_green = 1'b0;
			end
		endcase
	end

	// Flags only request a fault; latching and PWM shutdown live next door
	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			bus_over_volt_flag_out <= 1'b0;
		end else begin
			bus_over_volt_flag_out <= nxt_ov;
		end
	end

	// Undervoltage state is the flag itself, no shadow copy
	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			bus_under_volt_flag_out <= 1'b0;
		end else begin
			bus_under_volt_flag_out <= nxt_uv;
		end
	end

	// Brake off in reset: the safe state while nothing is known
	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			brake_on_out <= 1'b0;
		end else begin
			brake_on_out <= nxt_brake;
		end
	end

	// Lamps dark in reset, as before configuration
	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			fault_indicator_out <= 1'b0;
		end else begin
			fault_indicator_out <= nxt_red;
		end
	end

	// Green rises one clock after release, no host step needed
	always @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			healthy_indicator_out <= 1'b0;
		end else begin
			healthy_indicator_out <= nxt_green;
		end
	end
endmodule

// [sim/dcbp_props.sv]
// Checker on dcbp_top ports; bound below.
// Assumes the single clock_in domain and active-high reset_in.
module dcbp_props(input wire clock_in,reset_in,sample_valid_in,config_ok_in,hw_fail_in,
	input wire fault_latched_in,bus_over_volt_flag_out,bus_under_volt_flag_out,brake_on_out,
	input wire fault_indicator_out,healthy_indicator_out,input wire [11:0] bus_sample_in);
timeunit 1ns; timeprecision 1ns;
default clocking @(posedge clock_in); endclocking
default disable iff (reset_in);
wire v=sample_valid_in;
wire k=config_ok_in&&!hw_fail_in;
wire [11:0] s=bus_sample_in;
AST_OV: assert property(v|=>bus_over_volt_flag_out==($past(s)>=12'hd20)) else $error("ov");
AST_UVS: assert property(v&&s<=12'h3d0|=>bus_under_volt_flag_out) else $error("uv");
AST_UVC: assert property(v&&s>=12'h480|=>!bus_under_volt_flag_out) else $error("uv");
AST_BON: assert property(v&&s>=12'hc30|=>brake_on_out) else $error("brake");
AST_BOF: assert property(v&&s<=12'hb80|=>!brake_on_out) else $error("brake");
AST_HLD: assert property(!v|=>$stable({bus_over_volt_flag_out,bus_under_volt_flag_out,brake_on_out})) else $error("hold");
AST_DRK: assert property(!k|=>!fault_indicator_out&&!healthy_indicator_out) else $error("dark");
AST_RED: assert property(##1 fault_indicator_out==$past(k&&fault_latched_in)) else $error("red");
AST_GRN: assert property(##1 healthy_indicator_out==$past(k&&!fault_latched_in)) else $error("grn");
cover property(bus_over_volt_flag_out);
cover property(fault_indicator_out);
cover property(healthy_indicator_out);
cover property(brake_on_out&&bus_under_volt_flag_out==1'b0);
endmodule
bind dcbp_top dcbp_props u_props(.*);

// [sim/dcbp_adc.sv]
// Converter model: random samples, random strobe; full 12-bit span.
// Assumes the bench clock; words change on the falling edge only.
module dcbp_adc(
	input wire clock_in,
	output logic [11:0] sample_out,
	output logic valid_out);
timeunit 1ns; timeprecision 1ns;
int seed=32'h6e0b;
always @(negedge clock_in) begin valid_out<=$random(seed); sample_out<=$random(seed); end
endmodule

// [sim/tb.sv]
// Bench: reference model compared with dcbp_top every cycle.
// Assumes dcbp_adc as the converter and the checker bound into dcbp_top.
module tb;
timeunit 1ns; timeprecision 1ns;
logic clock_in=1'h0,reset_in=1'h1,m_ov=1'h0,m_uv=1'h0,m_br=1'h0,m_rd=1'h0,m_gn=1'h0;
logic [2:0] st=3'h0;
wire [11:0] s; wire v,ov,uv,br,rd,gn; int errors=0,checked=0;
`define CK(n,e,g) begin checked++; if((g)!==(e)) begin errors++; $display("wrong value %s exp %b got %b",n,e,g); end end
always #10 clock_in=~clock_in;
dcbp_adc adc(.clock_in(clock_in),.sample_out(s),.valid_out(v));
dcbp_top dut(.clock_in(clock_in),.reset_in(reset_in),.bus_sample_in(s),.sample_valid_in(v),
	.config_ok_in(st[0]),.hw_fail_in(st[1]),.fault_latched_in(st[2]),.bus_over_volt_flag_out(ov),
	.bus_under_volt_flag_out(uv),.brake_on_out(br),.fault_indicator_out(rd),.healthy_indicator_out(gn));
always @(negedge clock_in) st<=$random(adc.seed);
// Model steps on the design's edge; compared at the falling edge, once settled
always @(posedge clock_in or posedge reset_in) if(reset_in) begin
	m_ov<=1'h0; m_uv<=1'h0; m_br<=1'h0; m_rd<=1'h0; m_gn<=1'h0;
end else begin
	m_rd<=st==3'h5; m_gn<=st==3'h1;
	if(v) begin m_ov<=s>=12'hd20; if(s<=12'h3d0) m_uv<=1'h1; else if(s>=12'h480) m_uv<=1'h0;
		if(s>=12'hc30) m_br<=1'h1; else if(s<=12'hb80) m_br<=1'h0; end
end
always @(negedge clock_in) if(!reset_in) begin
	`CK("ov",m_ov,ov)
	`CK("uv",m_uv,uv)
	`CK("brake",m_br,br)
	`CK("red",m_rd,rd)
	`CK("green",m_gn,gn)
end else begin
	`CK("reset outputs",5'h0,{ov,uv,br,rd,gn})
end
task close_out; $display("checked %0d errors %0d",checked,errors);
	if(errors==0&&checked>0) $display("bench passed"); else $display("bench failed"); $finish; endtask
initial begin repeat(5) @(negedge clock_in); reset_in<=1'h0; repeat(1500) @(negedge clock_in);
	$display("test random done"); reset_in<=1'h1; repeat(5) @(negedge clock_in); reset_in<=1'h0;
	repeat(1500) @(negedge clock_in); $display("test reset done"); close_out; end
initial begin #80000; errors++; close_out; end
endmodule
